// ---- logic/ast_pkg.sv ----
// Package for the asynchronous serial transceiver.
// Holds register offsets, field positions, reset values and states.
package ast_pkg;

  // Register offsets on the plain register port
  localparam logic [2:0] MODE_OFS   = 3'h0;  // serial_mode_reg
  localparam logic [2:0] CTRL_OFS   = 3'h1;  // serial_control_reg
  localparam logic [2:0] BAUD_OFS   = 3'h2;  // 16x tick divisor
  localparam logic [2:0] TDATA_OFS  = 3'h3;  // tx_data_reg
  localparam logic [2:0] STAT_OFS   = 3'h4;  // serial_status_reg
  localparam logic [2:0] RDATA_OFS  = 3'h5;  // rx_data_reg
  localparam logic [2:0] PIN_OFS    = 3'h6;  // rx_line level

  // serial_mode_reg fields
  localparam int CHR_BIT  = 6;  // char_length_sel
  localparam int PE_BIT   = 5;  // parity_enable
  localparam int ODD_BIT  = 4;  // Odd parity select
  localparam int STOP_BIT = 3;  // Two stop bits
  localparam int MP_BIT   = 2;  // multiproc_format_sel

  // serial_control_reg fields
  localparam int TIE_BIT  = 7;  // tx_empty_irq_en
  localparam int RIE_BIT  = 6;  // rx_irq_en
  localparam int TE_BIT   = 5;  // tx_enable
  localparam int RE_BIT   = 4;  // rx_enable
  localparam int TX_DONE_IRQ_EN_BIT = 2;  // tx_done_irq_en
  localparam int CLK_SRC_SEL_HI_BIT = 1;  // clk_src_sel_hi
  localparam int CLK_SRC_SEL_LO_BIT = 0;  // clk_src_sel_lo

  // serial_status_reg fields
  localparam int TX_EMPTY_FLAG_BIT = 7;  // tx_empty_flag
  localparam int RX_FULL_FLAG_BIT = 6;  // rx_full_flag
  localparam int OVERRUN_FLAG_BIT = 5;  // overrun_flag
  localparam int FER_BIT  = 4;  // framing_err_flag
  localparam int PER_BIT  = 3;  // parity_err_flag
  localparam int TX_DONE_FLAG_BIT = 2;  // tx_done_flag
  localparam int MPBR_BIT = 1;  // Received multiproc_bit
  localparam int MPBT_BIT = 0;  // multiproc_bit to send

  // Reset value, bit phases and data lengths
  localparam logic [7:0] BAUD_RST = 8'h0F;  // Divisor reset value
  localparam logic [3:0] PH_LAST  = 4'hF;   // Last 16x tick of a bit
  localparam logic [3:0] PH_MID   = 4'h7;   // Eighth tick, bit centre
  localparam logic [2:0] LEN8     = 3'h7;   // Last index, 8 data bits
  localparam logic [2:0] LEN7     = 3'h6;   // Last index, 7 data bits

  // Transmit and receive states
  typedef enum logic [2:0] {
    AST_IDLE, AST_START, AST_DATA, AST_PAR, AST_STOP1, AST_STOP2
  } ast_state_e;

endpackage

// ---- logic/ast_serial_port.sv ----
// Asynchronous serial transceiver: transmitter, receiver, registers.
// Assumes one 25 MHz clock, a plain register port driven from the
// same clock, and rx_line and the serial clock pin from outside.
`timescale 1ns/1ns
`default_nettype none

module ast_serial_port
  import ast_pkg::*;
#(
  parameter logic [7:0] BAUD_DEFAULT = BAUD_RST  // Divisor after reset
) (
  input  wire logic       clk,           // 25 MHz clock
  input  wire logic       reset,         // Asynchronous, active high
  input  wire logic [2:0] addr,          // Register address
  input  wire logic [7:0] wdata,         // Write data
  input  wire logic       wr,            // Write strobe
  input  wire logic       rd,            // Read strobe
  input  wire logic       dma_read,      // Read strobe comes from DMA
  output logic      [7:0] rdata,         // Read data, cycle after rd
  input  wire logic       rx_line,       // Serial input pin
  output logic            tx_line,       // Serial output pin
  input  wire logic       sck_in,        // serial_clock_pin input
  output logic            sck_out,       // serial_clock_pin output
  output logic            sck_oe,        // serial_clock_pin enable
  output logic            tx_empty_irq,  // Transmit empty request
  output logic            tx_done_irq,   // Transmit end request
  output logic            rx_full_irq,   // Receive full request
  output logic            rx_err_irq     // Receive error request
);

  // Elaboration check: a zero divisor default is refused
  if (BAUD_DEFAULT == 8'h00) begin : g_bad_baud
    $error("BAUD_DEFAULT must be nonzero");
  end

  // Register file and flags
  logic [7:0] mode_r, ctrl_r, baud_r, tdata_r, rdata_r;
  logic [7:0] next_mode, next_ctrl, next_baud, next_tdata, next_rdata;
  logic       tx_empty_flag, rx_full_flag, overrun_flag, framing_err_flag, per, tx_done_flag, mpbr, mpbt;
  logic       next_tx_empty_flag, next_rx_full_flag, next_overrun_flag, next_fer, next_per;
  logic       next_tx_done_flag, next_mpbr, next_mpbt;
  logic [7:0] next_rdata_bus;
  // Synchronisers and tick generator
  logic       rx_s1, rx_s2, rx_s3;   // rx_line synchroniser
  logic       ck_s1, ck_s2, ck_s3;   // sck_in synchroniser
  logic [7:0] div_cnt, next_div_cnt; // Internal 16x divisor
  logic       tick;                  // One 16x pulse
  // Transmitter
  ast_state_e tx_st, next_tx_st;
  logic [3:0] tx_ph, next_tx_ph;     // 16x phase within a bit
  logic [2:0] tx_idx, next_tx_idx;   // Data bit index
  logic [7:0] tx_sh, next_tx_sh;     // tx_shift_reg
  logic       tx_par, next_tx_par;   // Parity or multiproc bit
  logic       next_tx_line, tx_load, tx_end;
  // Receiver
  ast_state_e rx_st, next_rx_st;
  logic [3:0] rx_ph, next_rx_ph;
  logic [2:0] rx_idx, next_rx_idx;
  logic [7:0] rx_sh, next_rx_sh;     // rx_shift_reg
  logic       rx_pb, next_rx_pb;     // Received parity / mp bit
  logic       rx_done, rx_perr;      // Frame complete, bad parity

  // Decoded mode and control bits
  logic ext_clk, two_stop, mp_fmt, par_en, err_any;
  assign ext_clk  = ctrl_r[CLK_SRC_SEL_HI_BIT];
  assign two_stop = mode_r[STOP_BIT];
  assign mp_fmt   = mode_r[MP_BIT];
  assign par_en   = mode_r[PE_BIT] & ~mode_r[MP_BIT];
  assign err_any  = overrun_flag | framing_err_flag | per;

  // Last data bit index for the chosen length
  function automatic logic [2:0] last_idx(input logic seven);
    last_idx = seven ? LEN7 : LEN8;
  endfunction

  // Parity bit of the data actually framed
  function automatic logic par_of(input logic [7:0] d,
                                  input logic seven, input logic odd);
    logic p;
    p = seven ? ^d[6:0] : ^d;
    par_of = p ^ odd;
  endfunction

  // State after the data bits, shared by both directions
  function automatic ast_state_e after_data(input logic mp,
                                             input logic pe);
    // parity, multiproc bit or straight to stop
    after_data = (mp | pe) ? AST_PAR : AST_STOP1;
  endfunction

  // 16x tick: internal divisor or external pin edge
  always_comb begin
    next_div_cnt = (div_cnt == 8'h00) ? baud_r : div_cnt - 8'h01;
    // external pin edge is one 16x tick
    tick = ext_clk ? (ck_s2 & ~ck_s3) : (div_cnt == 8'h00);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_cnt <= 8'h00;
      rx_s1   <= 1'b1;
      rx_s2   <= 1'b1;
      rx_s3   <= 1'b1;
      ck_s1   <= 1'b0;
      ck_s2   <= 1'b0;
      ck_s3   <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      rx_s1   <= rx_line;
      rx_s2   <= rx_s1;
      rx_s3   <= rx_s2;
      ck_s1   <= sck_in;
      ck_s2   <= ck_s1;
      ck_s3   <= ck_s2;
    end
  end

  // Transmitter sequencing
  always_comb begin
    next_tx_st   = tx_st;
    next_tx_ph   = tx_ph;
    next_tx_idx  = tx_idx;
    next_tx_sh   = tx_sh;
    next_tx_par  = tx_par;
    next_tx_line = 1'b1;
    tx_load      = 1'b0;
    tx_end       = 1'b0;
    if (tick)
      next_tx_ph = tx_ph + 4'h1;
    unique case (tx_st)
      AST_IDLE: begin
        // empty flag low means fresh data
        if (ctrl_r[TE_BIT] && !tx_empty_flag) begin
          tx_load     = 1'b1;
          next_tx_sh  = tdata_r;
          next_tx_par = mp_fmt ? mpbt
                      : par_of(tdata_r, mode_r[CHR_BIT], mode_r[ODD_BIT]);
          next_tx_st  = AST_START;
          next_tx_ph  = 4'h0;
        end
      end
      AST_START: begin
        next_tx_line = 1'b0;
        if (tick && tx_ph == PH_LAST) begin
          next_tx_st  = AST_DATA;
          next_tx_idx = 3'h0;
        end
      end
      AST_DATA: begin
        next_tx_line = tx_sh[0];
        if (tick && tx_ph == PH_LAST) begin
          next_tx_sh  = {1'b1, tx_sh[7:1]};
          next_tx_idx = tx_idx + 3'h1;
          if (tx_idx == last_idx(mode_r[CHR_BIT]))
            next_tx_st = after_data(mp_fmt, par_en);
        end
      end
      AST_PAR: begin
        next_tx_line = tx_par;
        if (tick && tx_ph == PH_LAST)
          next_tx_st = AST_STOP1;
      end
      default: begin
        // one or two high stop bits
        next_tx_line = 1'b1;
        if (tick && tx_ph == PH_LAST) begin
          if (tx_st == AST_STOP1 && two_stop) begin
            next_tx_st = AST_STOP2;
          // data waiting: load and chain the next frame
          end else if (ctrl_r[TE_BIT] && !tx_empty_flag) begin
            tx_load     = 1'b1;
            next_tx_sh  = tdata_r;
            next_tx_par = mp_fmt ? mpbt
                        : par_of(tdata_r, mode_r[CHR_BIT], mode_r[ODD_BIT]);
            next_tx_st  = AST_START;
          // nothing waiting: done, then mark state
          end else begin
            tx_end     = 1'b1;
            next_tx_st = AST_IDLE;
          end
        end
      end
    endcase
    // clearing transmit enable resets the shifter
    if (!ctrl_r[TE_BIT]) begin
      next_tx_st   = AST_IDLE;
      next_tx_sh   = 8'hFF;
      next_tx_line = 1'b1;
      tx_load      = 1'b0;
      tx_end       = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_st   <= AST_IDLE;
      tx_ph   <= 4'h0;
      tx_idx  <= 3'h0;
      tx_sh   <= 8'hFF;
      tx_par  <= 1'b1;
      tx_line <= 1'b1;
    end else begin
      tx_st   <= next_tx_st;
      tx_ph   <= next_tx_ph;
      tx_idx  <= next_tx_idx;
      tx_sh   <= next_tx_sh;
      tx_par  <= next_tx_par;
      tx_line <= next_tx_line;
    end
  end

  // Receiver sequencing
  always_comb begin
    next_rx_st  = rx_st;
    next_rx_ph  = rx_ph;
    next_rx_idx = rx_idx;
    next_rx_sh  = rx_sh;
    next_rx_pb  = rx_pb;
    rx_done     = 1'b0;
    rx_perr     = 1'b0;
    if (tick)
      next_rx_ph = rx_ph + 4'h1;
    unique case (rx_st)
      AST_IDLE: begin
        // no new frame while an error flag stands
        // synchronise on the falling start edge
        if (ctrl_r[RE_BIT] && !err_any && rx_s3 && !rx_s2) begin
          next_rx_st = AST_START;
          next_rx_ph = 4'h0;
        end
      end
      AST_START: begin
        // check the start bit at its centre
        if (tick && rx_ph == PH_MID) begin
          if (rx_s2)
            next_rx_st = AST_IDLE;
          else begin
            next_rx_st  = AST_DATA;
            next_rx_idx = 3'h0;
          end
        end
      end
      AST_DATA: begin
        // sample on the eighth tick of each bit
        if (tick && rx_ph == PH_MID) begin
          next_rx_sh  = {rx_s2, rx_sh[7:1]};
          next_rx_idx = rx_idx + 3'h1;
          if (rx_idx == last_idx(mode_r[CHR_BIT])) begin
            if (mode_r[CHR_BIT])
              next_rx_sh = {1'b0, rx_s2, rx_sh[7:2]};
            next_rx_st = after_data(mp_fmt, par_en);
          end
        end
      end
      AST_PAR: begin
        if (tick && rx_ph == PH_MID) begin
          next_rx_pb = rx_s2;
          next_rx_st = AST_STOP1;
        end
      end
      default: begin
        // First stop bit only is checked; frame ends at its centre
        if (tick && rx_ph == PH_MID) begin
          rx_done    = 1'b1;
          rx_perr    = par_en &&
            (rx_pb != par_of(rx_sh, mode_r[CHR_BIT], mode_r[ODD_BIT]));
          next_rx_st = AST_IDLE;
        end
      end
    endcase
    // disabling the receiver stops only the sequencer
    if (!ctrl_r[RE_BIT]) begin
      next_rx_st = AST_IDLE;
      rx_done    = 1'b0;
      rx_perr    = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_st  <= AST_IDLE;
      rx_ph  <= 4'h0;
      rx_idx <= 3'h0;
      rx_sh  <= 8'h00;
      rx_pb  <= 1'b0;
    end else begin
      rx_st  <= next_rx_st;
      rx_ph  <= next_rx_ph;
      rx_idx <= next_rx_idx;
      rx_sh  <= next_rx_sh;
      rx_pb  <= next_rx_pb;
    end
  end

  // Registers, status flags, read port and outputs
  always_comb begin
    next_mode  = mode_r;
    next_ctrl  = ctrl_r;
    next_baud  = baud_r;
    next_tdata = tdata_r;
    next_rdata = rdata_r;
    next_tx_empty_flag  = tx_empty_flag;
    next_rx_full_flag  = rx_full_flag;
    next_overrun_flag  = overrun_flag;
    next_fer   = framing_err_flag;
    next_per   = per;
    next_tx_done_flag  = tx_done_flag;
    next_mpbr  = mpbr;
    next_mpbt  = mpbt;
    // Software writes; status flags clear by writing zero, tx_done_flag by a zero in bit 7
    if (wr) begin
      unique case (addr)
        MODE_OFS:  next_mode  = wdata;
        CTRL_OFS:  next_ctrl  = wdata;
        BAUD_OFS:  next_baud  = wdata;
        TDATA_OFS: next_tdata = wdata;
        STAT_OFS: begin
          next_tx_empty_flag = tx_empty_flag & wdata[TX_EMPTY_FLAG_BIT];
          next_tx_done_flag = tx_done_flag & wdata[TX_EMPTY_FLAG_BIT];
          next_rx_full_flag = rx_full_flag & wdata[RX_FULL_FLAG_BIT];
          next_overrun_flag = overrun_flag & wdata[OVERRUN_FLAG_BIT];
          next_fer  = framing_err_flag  & wdata[FER_BIT];
          next_per  = per  & wdata[PER_BIT];
          next_mpbt = wdata[MPBT_BIT];
        end
        default: ;
      endcase
    end
    // DMA read of received data clears full flag
    if (rd && dma_read && addr == RDATA_OFS)
      next_rx_full_flag = 1'b0;
    // loading the shifter sets the empty flag
    if (tx_load)
      next_tx_empty_flag = 1'b1;
    if (tx_end)
      next_tx_done_flag = 1'b1;
    if (!next_ctrl[TE_BIT])
      next_tx_empty_flag = 1'b1;
    if (rx_done) begin
      // overrun keeps old data; other errors transfer
      if (rx_full_flag)
        next_overrun_flag = 1'b1;
      else begin
        next_rdata = rx_sh;
        next_mpbr  = mp_fmt & rx_pb;
        // Hardware set wins over a software clear in the same cycle
        next_fer   = next_fer | ~rx_s2;
        next_per   = next_per | rx_perr;
        // clean frame sets the full flag
        if (rx_s2 && !rx_perr)
          next_rx_full_flag = 1'b1;
      end
    end
    // Read data mux, presented the cycle after rd
    next_rdata_bus = 8'h00;
    if (rd) begin
      unique case (addr)
        MODE_OFS:  next_rdata_bus = mode_r;
        CTRL_OFS:  next_rdata_bus = ctrl_r;
        BAUD_OFS:  next_rdata_bus = baud_r;
        TDATA_OFS: next_rdata_bus = tdata_r;
        STAT_OFS:  next_rdata_bus = {tx_empty_flag, rx_full_flag, overrun_flag, framing_err_flag, per, tx_done_flag,
                                     mpbr, mpbt};
        RDATA_OFS: next_rdata_bus = rdata_r;
        // synchronised rx_line level for break checks
        PIN_OFS:   next_rdata_bus = {7'h00, rx_s2};
        default:   next_rdata_bus = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_r       <= 8'h00;
      ctrl_r       <= 8'h00;
      baud_r       <= BAUD_DEFAULT;
      tdata_r      <= 8'hFF;
      rdata_r      <= 8'h00;
      tx_empty_flag         <= 1'b1;
      rx_full_flag         <= 1'b0;
      overrun_flag         <= 1'b0;
      framing_err_flag          <= 1'b0;
      per          <= 1'b0;
      tx_done_flag         <= 1'b1;
      mpbr         <= 1'b0;
      mpbt         <= 1'b0;
      rdata        <= 8'h00;
      sck_out      <= 1'b0;
      sck_oe       <= 1'b0;
      tx_empty_irq <= 1'b0;
      tx_done_irq  <= 1'b0;
      rx_full_irq  <= 1'b0;
      rx_err_irq   <= 1'b0;
    end else begin
      mode_r       <= next_mode;
      ctrl_r       <= next_ctrl;
      baud_r       <= next_baud;
      tdata_r      <= next_tdata;
      rdata_r      <= next_rdata;
      tx_empty_flag         <= next_tx_empty_flag;
      rx_full_flag         <= next_rx_full_flag;
      overrun_flag         <= next_overrun_flag;
      framing_err_flag          <= next_fer;
      per          <= next_per;
      tx_done_flag         <= next_tx_done_flag;
      mpbr         <= next_mpbr;
      mpbt         <= next_mpbt;
      rdata        <= next_rdata_bus;
      // high in second half, rising at bit centre
      sck_out      <= tx_ph[3];
      // drive the pin only for internal clock output
      sck_oe       <= ~ctrl_r[CLK_SRC_SEL_HI_BIT] & ctrl_r[CLK_SRC_SEL_LO_BIT];
      tx_empty_irq <= ctrl_r[TIE_BIT] & tx_empty_flag;
      // end request follows the done flag
      tx_done_irq  <= ctrl_r[TX_DONE_IRQ_EN_BIT] & tx_done_flag;
      // full request follows the full flag
      rx_full_irq  <= ctrl_r[RIE_BIT] & rx_full_flag;
      rx_err_irq   <= ctrl_r[RIE_BIT] & err_any;
    end
  end

  // Checks on the sequencers and flags
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_ctrl_te_off;
    wr && addr == CTRL_OFS && !wdata[TE_BIT];
  endsequence

  // The flag is forced at once, the sequencer one cycle later
  te_clear_a: assert property (s_ctrl_te_off
    |=> tx_empty_flag ##1 (tx_st == AST_IDLE && tx_sh == 8'hFF))
    else $error("tx enable clear did not reset transmitter");
  tx_load_a: assert property (tx_load
    |=> tx_empty_flag && tx_st == AST_START)
    else $error("load did not set empty flag");
  start_low_a: assert property ((tx_st == AST_START) [*2]
    |-> !tx_line)
    else $error("start bit not low");
  idle_mark_a: assert property ((tx_st == AST_IDLE) [*2]
    |-> tx_line)
    else $error("line not high while idle");
  rx_block_a: assert property (err_any && rx_st == AST_IDLE
    |=> rx_st == AST_IDLE)
    else $error("reception started with error flag set");
  overrun_a: assert property (rx_done && rx_full_flag
    |=> overrun_flag && $stable(rdata_r))
    else $error("overrun not flagged");
  dma_clear_a: assert property (rd && dma_read && addr == RDATA_OFS
    && !rx_done |=> !rx_full_flag)
    else $error("dma read left full flag set");
  // A DMA read may still empty the buffer while receive is off
  rx_hold_a: assert property (!ctrl_r[RE_BIT] && !wr && !dma_read
    |=> $stable(rdata_r) && $stable(rx_full_flag))
    else $error("receiver disable changed data or flag");
  full_irq_a: assert property ($rose(rx_full_flag) && ctrl_r[RIE_BIT]
    |-> ##1 rx_full_irq)
    else $error("full request missing");

endmodule

`default_nettype wire

// ---- sim/ast_remote_dev.sv ----
// Remote serial device: drives frames and captures frames.
// Assumes a 16-clock bit time (divisor 0) on the shared clock.
`timescale 1ns/1ns
`default_nettype none
module ast_remote_dev (
  input  wire logic clk,  // Shared clock
  input  wire logic rx,   // From device tx_line
  output logic      tx    // To device rx_line
);
  // Line starts in mark state
  initial tx = 1'b1;
  task automatic send(input logic [11:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      tx <= b[i];
      repeat (15) @(posedge clk);
    end
  endtask
  // Wait for start edge, then sample each bit centre
  task automatic grab(output logic [11:0] b, input int n, output bit ok);
    int t;
    b = '0;
    t = 0;
    while (rx === 1'b1 && t < 4000) begin
      @(posedge clk);
      t++;
    end
    ok = (t < 4000);
    repeat (7) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      #1 b[i] = rx;
      repeat (16) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ---- sim/ast_serial_port_bench.sv ----
// Bench for the serial port: register tasks and frame checks.
// Assumes the remote model and divisor 0 (16 clocks per bit).
`timescale 1ns/1ns
`default_nettype none
module ast_serial_port_bench;
  import ast_pkg::*;
  logic        clk, reset, wr, rd, dma_read, rx_line, tx_line;
  logic        sck_in, sck_out, sck_oe, tx_empty_irq, tx_done_irq;
  logic        rx_full_irq, rx_err_irq;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata, v, d;
  logic [4:0]  f;
  logic [11:0] b;
  bit          ok;
  int          errors, samples_checked, n;

  ast_serial_port ast_serial_port_inst (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .dma_read(dma_read),
    .rdata(rdata), .rx_line(rx_line), .tx_line(tx_line), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe(sck_oe), .tx_empty_irq(tx_empty_irq),
    .tx_done_irq(tx_done_irq), .rx_full_irq(rx_full_irq),
    .rx_err_irq(rx_err_irq));
  ast_remote_dev ast_remote_dev_inst (.clk(clk), .rx(tx_line),
    .tx(rx_line));

  // Clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // external clock never stops; one tick per 4 clocks
  initial begin
    sck_in = 1'b0;
    forever begin
      repeat (2) @(posedge clk);
      sck_in <= ~sck_in;
    end
  end

  // Expected frame bits, start first, mark bit last
  function automatic logic [11:0] frame(input logic [7:0] dd,
      input logic [4:0] ff, input logic bad, output int len);
    int k;
    logic [11:0] r;
    r = '0;
    for (int j = 0; j < (ff[4] ? 7 : 8); j++) r[1+j] = dd[j];
    k = ff[4] ? 8 : 9;
    if (ff[0]) begin
      r[k] = ff[2];
      k++;
    end else if (ff[3]) begin
      r[k] = ^r[8:1] ^ ff[2];
      k++;
    end
    r[k] = !bad;
    k++;
    if (ff[1]) begin
      r[k] = 1'b1;
      k++;
    end
    r[k] = 1'b1;
    len = k + 1;
    return r;
  endfunction

  task automatic wreg(input logic [2:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [2:0] a, input logic dm,
      output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    dma_read <= dm;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    dma_read <= 1'b0;
    #1 q = rdata;
  endtask

  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Send one frame from the remote side
  task automatic rsend(input logic [7:0] x, input logic bad, input int cut);
    b = frame(x, 5'h00, bad, n);
    ast_remote_dev_inst.send(b, n - cut);
  endtask

  initial begin
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    dma_read = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rreg(STAT_OFS, 1'b0, v);
    chk(v, 8'h84);
    chk(tx_line, 1'b1);
    wreg(BAUD_OFS, 8'h00);
    // All twelve formats, odd and even parity mixed
    for (int i = 0; i < 16; i++) begin
      if (i[2] && i[1]) continue;
      f = {i[3], i[2], i[3] ^ i[0], i[0], i[1]};
      d = 8'hC5 ^ i[7:0];
      wreg(CTRL_OFS, 8'h00);
      wreg(MODE_OFS, {1'b0, f, 2'b00});
      wreg(CTRL_OFS, 8'hF4);
      wreg(TDATA_OFS, d);
      wreg(STAT_OFS, {1'b0, 4'hF, 2'b11, f[2]});
      b = frame(d, f, 1'b0, n);
      ast_remote_dev_inst.grab(b, n, ok);
      if (!ok) begin
        errors++;
        tally_and_finish;
      end
      chk(b, frame(d, f, 1'b0, n));
      chk(tx_empty_irq, 1'b1);
    end
    rreg(STAT_OFS, 1'b0, v);
    chk(v[TX_DONE_FLAG_BIT], 1'b1);
    chk(tx_done_irq, 1'b1);
    // Abort a frame of zeros in mid data
    wreg(TDATA_OFS, 8'h00);
    wreg(STAT_OFS, 8'h7B);
    repeat (40) @(posedge clk);
    #1 chk(tx_line, 1'b0);
    wreg(CTRL_OFS, 8'h54);
    repeat (3) @(posedge clk);
    #1 chk(tx_line, 1'b1);
    rreg(STAT_OFS, 1'b0, v);
    chk(v[TX_EMPTY_FLAG_BIT], 1'b1);
    // Receive 8N1, then overrun
    wreg(CTRL_OFS, 8'h00);
    wreg(MODE_OFS, 8'h00);
    wreg(CTRL_OFS, 8'h54);
    rsend(8'hA5, 1'b0, 0);
    chk(rx_full_irq, 1'b1);
    rreg(RDATA_OFS, 1'b0, v);
    chk(v, 8'hA5);
    rreg(RDATA_OFS, 1'b1, v);
    rreg(STAT_OFS, 1'b0, v);
    chk(v[RX_FULL_FLAG_BIT], 1'b0);
    rsend(8'h96, 1'b0, 0);
    rsend(8'h69, 1'b0, 0);
    chk(rx_err_irq, 1'b1);
    wreg(CTRL_OFS, 8'h44);
    rreg(STAT_OFS, 1'b0, v);
    chk(v & 8'h78, 8'h60);
    rreg(RDATA_OFS, 1'b0, v);
    chk(v, 8'h96);
    wreg(STAT_OFS, 8'h87);
    wreg(CTRL_OFS, 8'h54);
    // Framing error left as a break
    rsend(8'h3C, 1'b1, 1);
    rreg(STAT_OFS, 1'b0, v);
    chk(v & 8'h78, 8'h10);
    rreg(PIN_OFS, 1'b0, v);
    chk(v[0], 1'b0);
    ast_remote_dev_inst.send(12'h001, 1);
    rsend(8'h11, 1'b0, 0);
    rreg(RDATA_OFS, 1'b0, v);
    chk(v, 8'h3C);
    wreg(STAT_OFS, 8'h87);
    rsend(8'h5A, 1'b0, 0);
    rreg(RDATA_OFS, 1'b0, v);
    chk(v, 8'h5A);
    // Clock pin: bit-rate output, then external 16x input
    wreg(CTRL_OFS, 8'h00);
    wreg(CTRL_OFS, 8'h01);
    repeat (2) @(posedge clk);
    #1 v[0] = sck_out;
    repeat (8) @(posedge clk);
    #1 v[1] = sck_out;
    chk(sck_oe, 1'b1);
    chk(v[1] ^ v[0], 1'b1);
    wreg(CTRL_OFS, 8'h00);
    wreg(CTRL_OFS, 8'h22);
    wreg(TDATA_OFS, 8'h03);
    wreg(STAT_OFS, 8'h7B);
    repeat (40) @(posedge clk);
    #1 chk(tx_line, 1'b0);
    chk(sck_oe, 1'b0);
    repeat (60) @(posedge clk);
    #1 chk(tx_line, 1'b1);
    tally_and_finish;
  end
endmodule
`default_nettype wire
